// [src/swm_defines.vh]
// timing and command constants for the single-wire bus master
`ifndef SWM_DEFINES_VH
`define SWM_DEFINES_VH
`define SWM_CLK_MHZ 100
// times in microseconds
`define SWM_RST_LOW_STD_US 480
`define SWM_RST_LOW_OD_US 48
`define SWM_RST_HIGH_STD_US 480
`define SWM_RST_HIGH_OD_US 48
`define SWM_PRES_SAMPLE_STD_US 70
`define SWM_PRES_SAMPLE_OD_US 8
`define SWM_SLOT_STD_US 70
`define SWM_SLOT_OD_US 8
`define SWM_LOW1_STD_US 6
`define SWM_LOW1_OD_US 1
`define SWM_SAMPLE_STD_US 12
`define SWM_SAMPLE_OD_US 1
// cycles past the fast release before the read sample is taken
`define SWM_SAMPLE_OD_EXTRA_CYC 20'h00032
`define SWM_REC_US 2
// command codes
`define SWM_CMD_READ_ID 8'h33
`define SWM_CMD_MATCH 8'h55
`define SWM_CMD_SKIP 8'hCC
`define SWM_CMD_SEARCH 8'hF0
`define SWM_CMD_OD_SKIP 8'h3C
`define SWM_CMD_OD_MATCH 8'h69
// operation codes on the user port
`define SWM_OP_RESET 2'h0
`define SWM_OP_WRITE 2'h1
`define SWM_OP_READ 2'h2
`define SWM_OP_TRIPLET 2'h3
`endif

// [src/swm_master.v]
// single-wire bus master: reset/presence, bit slots, bytes and search triplets
`timescale 1ns/100ps
`include "swm_defines.vh"
module swm_master #(
    parameter RST_LOW_STD_CYC = `SWM_RST_LOW_STD_US * `SWM_CLK_MHZ,
    parameter RST_HIGH_STD_CYC = `SWM_RST_HIGH_STD_US * `SWM_CLK_MHZ
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // user command port
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire [7:0] cmd_data,
    input wire cmd_bit_only,
    input wire cmd_speed_od,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_data,
    output reg rsp_presence,
    output reg overdrive_flag,
    // bus pin
    input wire line_in,
    output reg line_out,
    output reg line_oe
);
    localparam ST_IDLE = 3'h0;
    localparam ST_RLOW = 3'h1;
    localparam ST_RHIGH = 3'h2;
    localparam ST_SLOT = 3'h3;
    localparam ST_REC = 3'h4;
    localparam ST_DONE = 3'h5;

    // converts microseconds to cycles, at least one
    function [19:0] us_cyc;
        input [31:0] us;
        reg [31:0] prod;
        begin
            prod = us * `SWM_CLK_MHZ;
            if (us == 0) begin
                us_cyc = 20'h00001;
            end else begin
                us_cyc = prod[19:0];
            end
        end
    endfunction

    reg sync1, line_s;
    reg [2:0] state;
    reg [19:0] cnt;
    reg [1:0] op;
    reg [7:0] shreg;
    reg [3:0] bits_left;
    reg [1:0] phase;
    reg trip_a, trip_b, trip_dir;
    reg cur_bit, sampled;
    reg od;

    wire [19:0] rlow = od ? us_cyc(`SWM_RST_LOW_OD_US) : RST_LOW_STD_CYC[19:0];
    wire [19:0] rhigh = od ? us_cyc(`SWM_RST_HIGH_OD_US) : RST_HIGH_STD_CYC[19:0];
    wire [19:0] psamp = od ? us_cyc(`SWM_PRES_SAMPLE_OD_US) : us_cyc(`SWM_PRES_SAMPLE_STD_US);
    wire [19:0] slot = od ? us_cyc(`SWM_SLOT_OD_US) : us_cyc(`SWM_SLOT_STD_US);
    wire [19:0] low1 = od ? us_cyc(`SWM_LOW1_OD_US) : us_cyc(`SWM_LOW1_STD_US);
    // fast read sample lands 50 cycles (SWM_SAMPLE_OD_EXTRA_CYC) after the release point
    wire [19:0] samp = od ? us_cyc(`SWM_SAMPLE_OD_US) + `SWM_SAMPLE_OD_EXTRA_CYC :
                       us_cyc(`SWM_SAMPLE_STD_US);
    wire [19:0] rec = us_cyc(`SWM_REC_US);
    // bit sent in the current slot: write uses data lsb, the third triplet slot sends trip_dir, reads send a one
    wire tx_bit = (op == `SWM_OP_WRITE) ? shreg[0] :
                  (op == `SWM_OP_TRIPLET && phase == 2'h2) ? trip_dir : 1'b1;

    // two-flop input synchroniser
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b1;
            line_s <= 1'b1;
        end else begin
            sync1 <= line_in;
            line_s <= sync1;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= 20'h00000;
            op <= 2'h0;
            shreg <= 8'h00;
            bits_left <= 4'h0;
            phase <= 2'h0;
            trip_a <= 1'b0;
            trip_b <= 1'b0;
            trip_dir <= 1'b0;
            cur_bit <= 1'b1;
            sampled <= 1'b1;
            od <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_presence <= 1'b0;
            overdrive_flag <= 1'b0;
            line_out <= 1'b0;
            line_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            line_out <= 1'b0;
            overdrive_flag <= od;
            case (state)
                ST_IDLE: begin
                    line_oe <= 1'b0;
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op <= cmd_op;
                        shreg <= cmd_data;
                        bits_left <= cmd_bit_only ? 4'h1 : 4'h8;
                        phase <= 2'h0;
                        trip_dir <= cmd_data[0];
                        cnt <= 20'h00000;
                        if (cmd_op == `SWM_OP_RESET) begin
                            od <= cmd_speed_od;
                            line_oe <= 1'b1;
                            state <= ST_RLOW;
                        end else begin
                            line_oe <= 1'b1;
                            state <= ST_SLOT;
                        end
                    end
                end
                ST_RLOW: begin
                    cnt <= cnt + 20'h00001;
                    if (cnt >= rlow - 20'h00001) begin
                        line_oe <= 1'b0;
                        cnt <= 20'h00000;
                        rsp_presence <= 1'b0;
                        state <= ST_RHIGH;
                    end
                end
                ST_RHIGH: begin
                    cnt <= cnt + 20'h00001;
                    if (cnt == psamp) begin
                        rsp_presence <= ~line_s;
                    end
                    if (cnt >= rhigh - 20'h00001) begin
                        state <= ST_DONE;
                    end
                end
                ST_SLOT: begin
                    cnt <= cnt + 20'h00001;
                    if (cnt == low1 - 20'h00001 && tx_bit) begin
                        line_oe <= 1'b0;
                    end
                    if (cnt == samp) begin
                        sampled <= line_s;
                    end
                    if (cnt >= slot - 20'h00001) begin
                        line_oe <= 1'b0;
                        cnt <= 20'h00000;
                        cur_bit <= (op == `SWM_OP_WRITE) ? tx_bit : sampled;
                        state <= ST_REC;
                    end
                end
                ST_REC: begin
                    cnt <= cnt + 20'h00001;
                    if (cnt >= rec - 20'h00001) begin
                        cnt <= 20'h00000;
                        if (op == `SWM_OP_TRIPLET) begin
                            if (phase == 2'h0) begin
                                trip_a <= cur_bit;
                                phase <= 2'h1;
                                line_oe <= 1'b1;
                                state <= ST_SLOT;
                            end else if (phase == 2'h1) begin
                                trip_b <= cur_bit;
                                if (trip_a != cur_bit) begin
                                    trip_dir <= trip_a;
                                end
                                phase <= 2'h2;
                                line_oe <= 1'b1;
                                state <= ST_SLOT;
                            end else begin
                                shreg <= {5'h00, trip_dir, trip_b, trip_a};
                                state <= ST_DONE;
                            end
                        end else begin
                            shreg <= {cur_bit, shreg[7:1]};
                            bits_left <= bits_left - 4'h1;
                            if (bits_left == 4'h1) begin
                                state <= ST_DONE;
                            end else begin
                                line_oe <= 1'b1;
                                state <= ST_SLOT;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    rsp_valid <= 1'b1;
                    rsp_data <= shreg;
                    state <= ST_IDLE;
                end
                default: begin
                    line_oe <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// [testbench/swm_chk.sv]
// port assertions for the single-wire master
`timescale 1ns/100ps
module swm_chk #(parameter RST_LOW_STD_CYC = 48000) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // user port
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire cmd_speed_od,
    input wire cmd_ready,
    input wire rsp_valid,
    input wire overdrive_flag,
    // bus pin
    input wire line_out,
    input wire line_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    localparam [19:0] RSTL = RST_LOW_STD_CYC;
    reg [19:0] lo_cnt;
    reg op_rst;
    reg op_od;
    wire tk = cmd_valid && cmd_ready;
    wire [19:0] rmin = op_od ? 20'h012C0 : RSTL;
    wire fell_rst;
    wire fell_slot;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lo_cnt <= 20'h00000;
            op_rst <= 1'b0;
            op_od <= 1'b0;
        end else begin
            lo_cnt <= line_oe ? lo_cnt + 20'h00001 : 20'h00000;
            if (tk) begin
                op_rst <= cmd_op == 2'h0;
                op_od <= cmd_op == 2'h0 ? cmd_speed_od : overdrive_flag;
            end
        end
    end
    sequence s_take(op);
        tk && cmd_op == op;
    endsequence
    sequence s_end_low;
        !line_oe && lo_cnt != 20'h00000;
    endsequence
    assign fell_rst = op_rst && !line_oe && lo_cnt != 20'h00000;
    assign fell_slot = !op_rst && !line_oe && lo_cnt != 20'h00000;
    chk_drive_low: assert property (line_oe |-> line_out == 1'b0)
        else $error("master drove the line high");
    chk_idle_free: assert property (cmd_ready |-> !line_oe)
        else $error("line held low while idle");
    chk_reset_long: assert property (s_end_low ##0 op_rst |-> lo_cnt >= rmin - 20'h00002)
        else $error("reset pulse too short");
    chk_reset_cap: assert property (fell_rst |-> lo_cnt < (op_od ? 20'h01F40 : 2 * RSTL))
        else $error("reset pulse too long");
    chk_slot_bound: assert property (fell_slot |-> lo_cnt <= (op_od ? 20'h00640 : 20'h02EE0))
        else $error("slot low beyond bound");
    chk_slot_shape: assert property (fell_slot |-> lo_cnt <= (op_od ? 20'h000C8 : 20'h005DC)
        || lo_cnt >= (op_od ? 20'h00258 : 20'h01770))
        else $error("slot low inside sampling window");
    chk_slot_opens: assert property (tk && cmd_op != 2'h0 |-> ##[1:4] line_oe)
        else $error("slot not opened by falling edge");
    chk_reset_opens: assert property (s_take(2'h0) |-> ##[1:4] line_oe [*8])
        else $error("reset pulse missing");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
        else $error("response not a single pulse");
    chk_speed_set: assert property (rsp_valid && op_rst |-> overdrive_flag == op_od)
        else $error("speed flag wrong after reset");
endmodule
bind swm_master swm_chk #(.RST_LOW_STD_CYC(RST_LOW_STD_CYC)) i_swm_chk (.clk_sys, .rst_n,
    .cmd_valid, .cmd_op, .cmd_speed_od, .cmd_ready, .rsp_valid, .overdrive_flag,
    .line_out, .line_oe);

// [testbench/swm_dev.sv]
// behavioural device on the far side of the single-wire bus
`timescale 1ns/100ps
module swm_dev (
    // bus level
    input wire line,
    // 0 listen, 1 send id bits, 2 search triplets
    input wire [1:0] mode,
    input wire [7:0] id,
    // device state
    output reg pull,
    output reg od,
    output reg [7:0] rx
);
    time t0;
    integer n;
    reg odl;
    initial begin
        pull = 0;
        od = 0;
        rx = 8'h00;
        n = 0;
    end
    always @(mode) n = 0;
    always @(negedge line) if (!pull) begin
        t0 = $time;
        odl = od;
        if (mode != 2'h0 && !(mode == 2'h2 && n % 3 == 2)) begin
            pull = !((mode == 2'h1 ? id[n % 8] : id[n / 3 % 8]) ^ (mode == 2'h2 && n % 3 == 1));
            #(od ? 2000 : 30000) pull = 0;
        end else begin
            #(od ? 3000 : 30000) rx = {line, rx[7:1]};
            if (n == 7 && rx == 8'h3C) od = 1;
        end
        n = n + 1;
        if (!line) @(posedge line);
        if ($time - t0 >= (odl ? 40000 : 80000)) begin
            if ($time - t0 >= 80000) od = 0;
            n = 0;
            #(od ? 2000 : 15000) pull = 1;
            #(od ? 8000 : 60000) pull = 0;
        end
    end
endmodule

// [testbench/swm_master_tb.sv]
// self-checking bench for the single-wire master
`timescale 1ns/100ps
module swm_master_tb;
    reg clk_sys = 0;
    reg rst_n = 0;
    reg cmd_valid = 0;
    reg [1:0] cmd_op = 0;
    reg [7:0] cmd_data = 0;
    reg cmd_bit_only = 0;
    reg cmd_speed_od = 0;
    reg [1:0] mode = 0;
    reg [7:0] id = 8'hA6; // arbitrary
    reg [7:0] rnd;
    wire cmd_ready, rsp_valid, rsp_presence, overdrive_flag, line_out, line_oe, pull, dev_od;
    wire [7:0] rsp_data, rx;
    wire line = !(line_oe | pull);
    integer failures = 0, n_checks = 0, cyc = 0, seed = 32'h7bd34a37;
    always #5 clk_sys = ~clk_sys;
    swm_master #(.RST_LOW_STD_CYC(8500), .RST_HIGH_STD_CYC(8000)) i_swm_master (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_bit_only(cmd_bit_only), .cmd_speed_od(cmd_speed_od),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_presence(rsp_presence), .overdrive_flag(overdrive_flag), .line_in(line),
        .line_out(line_out), .line_oe(line_oe));
    swm_dev i_swm_dev (.line(line), .mode(mode), .id(id), .pull(pull), .od(dev_od), .rx(rx));
    task test_done;
        begin
            if (failures == 0 && n_checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task check(input [7:0] seen, input [7:0] want, input [63:0] what);
        begin
            n_checks = n_checks + 1;
            if (seen !== want) begin
                failures = failures + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    task run(input [1:0] op, input [7:0] d, input b, input od);
        begin
            cmd_op = op;
            cmd_data = d;
            cmd_bit_only = b;
            cmd_speed_od = od;
            cmd_valid = 1;
            while (cmd_ready !== 1'b1) @(posedge clk_sys) #1;
            @(posedge clk_sys) #1 cmd_valid = 0;
            while (rsp_valid !== 1'b1) @(posedge clk_sys) #1;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 130000) begin
            failures = failures + 1;
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 rst_n = 1;
        rnd = $random(seed);
        run(2'h0, 8'h00, 0, 0);
        check({7'h0, rsp_presence}, 8'h01, "pres");
        run(2'h1, 8'h3C, 0, 0);
        check(rsp_data, 8'h3C, "wr_cmd");
        check({7'h0, dev_od}, 8'h01, "dev_od");
        run(2'h0, 8'h00, 0, 1);
        check({6'h0, overdrive_flag, rsp_presence}, 8'h03, "od_pres");
        run(2'h1, rnd, 0, 0);
        check(rx, rnd, "dev_rx");
        mode = 2'h1;
        run(2'h2, 8'h00, 0, 0);
        check(rsp_data, id, "rd_id");
        mode = 2'h2;
        run(2'h3, 8'h00, 0, 0);
        check(rsp_data, {5'h0, id[0], !id[0], id[0]}, "triplet");
        mode = 2'h1;
        run(2'h2, 8'h00, 1, 0);
        check({7'h0, rsp_data[7]}, {7'h0, id[0]}, "rd_bit");
        mode = 2'h0;
        run(2'h0, 8'h00, 0, 0);
        check({6'h0, overdrive_flag, dev_od}, 8'h00, "od_clr");
        test_done;
    end
endmodule
